/* hw/sfp_pkg.sv */
// Package with the shared constants of the slave FIFO port.
package sfp_pkg;
	localparam int          DATA_W        = 16;
	localparam int          SEL_W         = 5;
	localparam int          DEPTH_LOG2    = 4;
	localparam int          READ_LAT      = 2;
	localparam int          FLAG_LAT      = 3;
	localparam int          SEL_LAT       = 3;
	localparam int          SSD_MIN       = 2;
	localparam int          SSD_MAX       = 68;
	localparam logic [6:0]  SSD_DEFAULT   = 7'h04;
	localparam logic [1:0]  FLAG_EMPTY    = 2'h0;
	localparam logic [1:0]  FLAG_FULL     = 2'h1;
	localparam logic [1:0]  FLAG_PARTIAL  = 2'h2;
	localparam int          PARTIAL_LEVEL = 4;
	localparam int          CLK_DIV       = 2;
endpackage : sfp_pkg

/* hw/sfp_if.sv */
// Interface carrying the slave FIFO pins between master and device.
`timescale 1ns/1ps
`default_nettype none
interface sfp_if;
	logic                         link_clk;
	logic                         fifo_chip_select_n;
	logic                         fifo_output_enable_n;
	logic                         fifo_read_strobe_n;
	logic                         fifo_write_strobe_n;
	logic                         packet_end_strobe_n;
	logic                         socket_switch_strobe_n;
	logic [sfp_pkg::SEL_W-1:0]    fifo_select_lines;
	logic [sfp_pkg::DATA_W-1:0]   dq_from_master;
	logic                         dq_master_oe_n;
	logic [sfp_pkg::DATA_W-1:0]   dq_from_device;
	logic                         dq_device_oe_n;
	logic                         flag_status;
	logic                         flag_thread_ready;
	modport device (
		input  link_clk, fifo_chip_select_n, fifo_output_enable_n,
		input  fifo_read_strobe_n, fifo_write_strobe_n,
		input  packet_end_strobe_n, socket_switch_strobe_n,
		input  fifo_select_lines, dq_from_master, dq_master_oe_n,
		output dq_from_device, dq_device_oe_n,
		output flag_status, flag_thread_ready
	);
	modport master (
		output link_clk, fifo_chip_select_n, fifo_output_enable_n,
		output fifo_read_strobe_n, fifo_write_strobe_n,
		output packet_end_strobe_n, socket_switch_strobe_n,
		output fifo_select_lines, dq_from_master, dq_master_oe_n,
		input  dq_from_device, dq_device_oe_n,
		input  flag_status, flag_thread_ready
	);
endinterface : sfp_if
`default_nettype wire

/* hw/sfp_device.sv */
// Device end of the synchronous slave FIFO port, on the link clock.
`timescale 1ns/1ps
`default_nettype none
module sfp_device #(
	parameter int         NSOCK    = 4,
	parameter int         DEPTH_L2 = sfp_pkg::DEPTH_LOG2,
	parameter logic [6:0] SSD_CYC  = sfp_pkg::SSD_DEFAULT
) (
	// Link pins.
	sfp_if.device                     lnk,
	// Reset, synchronised locally to the link clock.
	input  wire logic                 i_arst_n,
	// Configuration: flag mode, fixed-thread use, select width.
	input  wire logic [1:0]           i_flag_mode,
	input  wire logic                 i_flag_fixed,
	input  wire logic [1:0]           i_flag_thread,
	input  wire logic                 i_sel_five_bit,
	input  wire logic [NSOCK-1:0]     i_sock_producer,
	// Packet commit events, one pulse each.
	output logic                      o_pkt_commit,
	output logic                      o_pkt_zero_len,
	output logic [1:0]                o_pkt_sock
);
	localparam int D = 1 << DEPTH_L2;
	typedef logic [DEPTH_L2:0] sfp_ptr_t;
	typedef struct packed {
		sfp_ptr_t   [NSOCK-1:0]        wp;
		sfp_ptr_t   [NSOCK-1:0]        rp;
		logic [2:0]                      sel_d;
		logic [2:0][1:0]                 sel_pipe;
		logic [1:0][sfp_pkg::DATA_W-1:0] rd_pipe;
		logic [2:0]                      flag_pipe;
		logic [6:0]                      ssd_cnt;
		logic                            ssd_busy;
		logic                            commit;
		logic                            zlp;
		logic [1:0]                      psock;
	} sfp_dev_st_t;
	sfp_dev_st_t st_ff, nxt_st;
	logic [sfp_pkg::DATA_W-1:0] mem_ff [NSOCK][D];
	logic [1:0] rst_sync_ff;
	wire        rst_n = rst_sync_ff[1];
	logic [1:0] sk, cur;
	logic       rd, wr, pe, empt, full;
	logic [DEPTH_L2:0] lvl;

	// Reset release is synchronised so that pointers leave reset cleanly.
	always_ff @(posedge lnk.link_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end

	// chip select gate. Pins share the link clock, so no sync.
	always_comb begin
		sk = lnk.fifo_select_lines[1:0];
		rd = !lnk.fifo_chip_select_n && !lnk.fifo_read_strobe_n;
		wr = !lnk.fifo_chip_select_n && !lnk.fifo_write_strobe_n;
		pe = !lnk.fifo_chip_select_n && !lnk.packet_end_strobe_n;
	end

	// Status of the selected flag thread, evaluated on the current pointers.
	always_comb begin
		cur  = i_flag_fixed ? i_flag_thread : st_ff.sel_pipe[0];
		lvl  = st_ff.wp[cur] - st_ff.rp[cur];
		empt = (lvl == '0);
		full = (lvl == (DEPTH_L2+1)'(D));
	end

	// Next-state logic for all pointers and pipelines.
	always_comb begin
		nxt_st        = st_ff;
		nxt_st.commit = 1'b0;
		nxt_st.zlp    = 1'b0;
		// select reaches the flags one edge later through sel_pipe[0]; the read bus uses it undelayed.
		nxt_st.sel_pipe = {st_ff.sel_pipe[1:0], sk};
		// read advances pointer. every edge in burst.
		if (rd && (st_ff.wp[sk] != st_ff.rp[sk])) begin
			nxt_st.rp[sk] = st_ff.rp[sk] + 1'b1;
		end
		// write stores word and advances. each edge.
		if (wr && !((st_ff.wp[sk] - st_ff.rp[sk]) ==
				(DEPTH_L2+1)'(D))) begin
			nxt_st.wp[sk] = st_ff.wp[sk] + 1'b1;
		end
		// commit with last word. zero length alone.
		if (pe) begin
			nxt_st.commit = 1'b1;
			nxt_st.zlp    = !wr;
			nxt_st.psock  = sk;
		end
		// two-stage read pipe. head of FIFO shown before read.
		nxt_st.rd_pipe = {st_ff.rd_pipe[0],
			mem_ff[sk][st_ff.rp[sk][DEPTH_L2-1:0]]};
		case (i_flag_mode)
			sfp_pkg::FLAG_EMPTY: nxt_st.flag_pipe[0] = !empt;
			sfp_pkg::FLAG_FULL:  nxt_st.flag_pipe[0] = !full;
			sfp_pkg::FLAG_PARTIAL: nxt_st.flag_pipe[0] =
				lvl < (DEPTH_L2+1)'(sfp_pkg::PARTIAL_LEVEL);
			default:             nxt_st.flag_pipe[0] = !empt;
		endcase
		nxt_st.flag_pipe[2:1] = st_ff.flag_pipe[1:0];
		// switch delay count. only five-bit select.
		if (!lnk.socket_switch_strobe_n && i_sel_five_bit) begin
			nxt_st.ssd_busy = 1'b1;
			nxt_st.ssd_cnt  = SSD_CYC;
		end else if (st_ff.ssd_cnt != 7'h00) begin
			nxt_st.ssd_cnt = st_ff.ssd_cnt - 7'h01;
		end else begin
			nxt_st.ssd_busy = 1'b0;
		end
	end

	// State register. Memory has no reset: contents are don't-care.
	always_ff @(posedge lnk.link_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Storage array written on accepted writes.
	always_ff @(posedge lnk.link_clk) begin
		if (nxt_st.wp[sk] != st_ff.wp[sk]) begin
			mem_ff[sk][st_ff.wp[sk][DEPTH_L2-1:0]] <= lnk.dq_from_master;
		end
	end

	// Pin outputs and commit events.
	always_comb begin
		// output enable only steers drive. drive while low.
		lnk.dq_device_oe_n = lnk.fifo_output_enable_n;
		lnk.dq_from_device = st_ff.rd_pipe[1];
		lnk.flag_status    = st_ff.flag_pipe[2];
		// producer needs space, consumer needs data.
		lnk.flag_thread_ready = !st_ff.ssd_busy && (
			i_sock_producer[st_ff.sel_pipe[0]] ?
			((st_ff.wp[st_ff.sel_pipe[0]] - st_ff.rp[st_ff.sel_pipe[0]])
				!= (DEPTH_L2+1)'(D)) :
			(st_ff.wp[st_ff.sel_pipe[0]] != st_ff.rp[st_ff.sel_pipe[0]]));
		o_pkt_commit   = st_ff.commit;
		o_pkt_zero_len = st_ff.zlp;
		o_pkt_sock     = st_ff.psock;
	end
endmodule : sfp_device
`default_nettype wire

/* hw/sfp_master.sv */
// Master end of the slave FIFO port; drives the link clock by a divider.
`timescale 1ns/1ps
`default_nettype none
module sfp_master (
	// System clock and reset.
	input  wire logic                       i_clk,
	input  wire logic                       i_arst_n,
	// Link pins.
	sfp_if.master                           lnk,
	// User command: 0 write word, 1 read word, 2 packet end, 3 switch.
	input  wire logic                       i_req,
	input  wire logic [1:0]                 i_cmd,
	input  wire logic [sfp_pkg::SEL_W-1:0]  i_sel,
	input  wire logic [sfp_pkg::DATA_W-1:0] i_wdata,
	output logic                            o_busy,
	// Read answer and flag levels.
	output logic                            o_rvalid,
	output logic [sfp_pkg::DATA_W-1:0]      o_rdata,
	output logic                            o_flag,
	output logic                            o_ready
);
	typedef enum logic [2:0] {
		SFP_IDLE = 3'h0, SFP_SETUP = 3'h1, SFP_STROBE = 3'h2,
		SFP_WAIT = 3'h3, SFP_DONE = 3'h4
	} sfp_state_t;
	typedef struct packed {
		sfp_state_t                 state;
		logic                       div;
		logic [1:0]                 cmd;
		logic [sfp_pkg::SEL_W-1:0]  sel;
		logic [sfp_pkg::DATA_W-1:0] wdata;
		logic [sfp_pkg::DATA_W-1:0] rdata;
		logic [2:0]                 wait_cnt;
		logic                       rvalid;
		logic [1:0]                 flag_s1;
		logic [1:0]                 flag_s2;
	} sfp_mst_st_t;
	sfp_mst_st_t st_ff, nxt_st;
	logic link_rise;

	// Pin changes happen only on the link falling edge, so the device,
	// which samples on the rising edge, sees clean setup and hold.
	always_comb begin
		nxt_st        = st_ff;
		nxt_st.div    = !st_ff.div;
		link_rise     = !st_ff.div;
		nxt_st.rvalid = 1'b0;
		nxt_st.flag_s1 = {lnk.flag_status, lnk.flag_thread_ready};
		nxt_st.flag_s2 = st_ff.flag_s1;
		// Advance only when the link clock is about to fall, never with
		// the rising edge at which the device samples the pins.
		if (link_rise) begin
		end else begin
			case (st_ff.state)
				SFP_IDLE: begin
					if (i_req) begin
						nxt_st.cmd   = i_cmd;
						nxt_st.sel   = i_sel;
						nxt_st.wdata = i_wdata;
						nxt_st.state = SFP_SETUP;
					end
				end
				// select and chip select settle before strobe.
				SFP_SETUP: nxt_st.state = SFP_STROBE;
				SFP_STROBE: begin
					// The rise that samples the strobe is the first one.
					nxt_st.wait_cnt = 3'h1;
					nxt_st.state    = (st_ff.cmd == 2'h1) ?
						SFP_WAIT : SFP_DONE;
				end
				// data arrives two link edges after read strobe.
				SFP_WAIT: begin
					nxt_st.wait_cnt = st_ff.wait_cnt + 3'h1;
					// Take the word that the device put on the bus at the last rise.
					if (st_ff.wait_cnt + 3'h1 ==
							3'(sfp_pkg::READ_LAT)) begin
						nxt_st.rdata  = lnk.dq_from_device;
						nxt_st.rvalid = 1'b1;
						nxt_st.state  = SFP_DONE;
					end
				end
				// select held through the packet end strobe.
				SFP_DONE: nxt_st.state = SFP_IDLE;
				default:  nxt_st.state = SFP_IDLE;
			endcase
		end
	end

	// State register.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Pin drive from registered state.
	always_comb begin
		logic act;
		logic stb;
		act = (st_ff.state != SFP_IDLE);
		stb = (st_ff.state == SFP_STROBE);
		lnk.link_clk             = st_ff.div;
		lnk.fifo_select_lines    = st_ff.sel;
		lnk.fifo_chip_select_n   = !act;
		// enable held from strobe until data captured.
		lnk.fifo_output_enable_n = !(st_ff.cmd == 2'h1 &&
			(stb || st_ff.state == SFP_WAIT));
		lnk.fifo_read_strobe_n   = !(stb && st_ff.cmd == 2'h1);
		lnk.fifo_write_strobe_n  = !(stb && st_ff.cmd == 2'h0);
		lnk.packet_end_strobe_n  = !(stb && st_ff.cmd == 2'h2);
		lnk.socket_switch_strobe_n = !(stb && st_ff.cmd == 2'h3);
		lnk.dq_from_master       = st_ff.wdata;
		lnk.dq_master_oe_n       = !(act && st_ff.cmd == 2'h0);
		o_busy   = act;
		o_rvalid = st_ff.rvalid;
		o_rdata  = st_ff.rdata;
		o_flag   = st_ff.flag_s2[1];
		o_ready  = st_ff.flag_s2[0];
	end
endmodule : sfp_master
`default_nettype wire

/* testbench/sfp_link_sva.sv */
// Checker of the link pins between the two ends of the FIFO port.
`timescale 1ns/1ps
`default_nettype none
module sfp_link_sva (
	// Link clock and reset.
	input wire logic                        link_clk,
	input wire logic                        i_arst_n,
	// Link pins.
	input wire logic                        fifo_chip_select_n,
	input wire logic                        fifo_output_enable_n,
	input wire logic                        fifo_read_strobe_n,
	input wire logic                        fifo_write_strobe_n,
	input wire logic                        socket_switch_strobe_n,
	input wire logic                        dq_master_oe_n,
	input wire logic [sfp_pkg::DATA_W-1:0]  dq_from_device,
	input wire logic                        dq_device_oe_n,
	input wire logic                        flag_status,
	input wire logic                        flag_thread_ready
);
	logic [2:0] live_ff;
	logic [2:0] quiet_ff;
	// The device leaves reset two edges late, so judge only after that.
	always_ff @(posedge link_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			live_ff  <= 3'h0;
			quiet_ff <= 3'h0;
		end else begin
			live_ff  <= (live_ff == 3'h7) ? live_ff : live_ff + 3'h1;
			quiet_ff <= !fifo_chip_select_n ? 3'h0 :
				(quiet_ff == 3'h7) ? quiet_ff : quiet_ff + 3'h1;
		end
	end
	default clocking cb @(posedge link_clk); endclocking
	default disable iff (!i_arst_n || live_ff != 3'h7);
	AST_OE_OFF: assert property (fifo_output_enable_n |-> dq_device_oe_n)
		else $error("device drives bus without output enable");
	AST_OE_ON: assert property (!fifo_output_enable_n |-> !dq_device_oe_n)
		else $error("device not driving bus under output enable");
	AST_NO_FIGHT: assert property (!dq_device_oe_n |-> dq_master_oe_n)
		else $error("both ends drive the data bus");
	AST_RD_HOLD: assert property (!fifo_chip_select_n && !fifo_read_strobe_n
		|=> $stable(dq_from_device))
		else $error("read data appeared one cycle early");
	AST_FLAG_HOLD: assert property (!fifo_chip_select_n && !fifo_write_strobe_n
		|=> $stable(flag_status) [*2])
		else $error("flag moved before three cycles");
	AST_SW_READY: assert property (!fifo_chip_select_n && !socket_switch_strobe_n
		|-> ##[2:68] flag_thread_ready)
		else $error("thread ready late after switch");
	AST_FLAG_CAUSE: assert property ($changed(flag_status) |-> quiet_ff < 3'h6)
		else $error("flag moved without chip select");
	AST_DQ_CAUSE: assert property ($changed(dq_from_device) |-> quiet_ff < 3'h6)
		else $error("data moved without chip select");
endmodule : sfp_link_sva
`default_nettype wire

/* testbench/sync_slave_fifo_port_tb.sv */
// Testbench joining master and device ends of the FIFO port.
`timescale 1ns/1ps
`default_nettype none
module sync_slave_fifo_port_tb;
	logic        i_clk = 1'b0;
	logic        i_arst_n = 1'b0;
	logic        req = 1'b0;
	logic [1:0]  cmd = 2'h0;
	logic [4:0]  sel = 5'h00;
	logic [15:0] wdata = 16'h0000;
	logic        busy, rvalid, flag, ready, commit, zlp;
	logic [15:0] rdata;
	logic [1:0]  psock;
	logic [15:0] rq [$];
	int          bad_count = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          n_zlp = 0;
	int          n_commit = 0;
	sfp_if lnk ();
	sfp_master sfp_master_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .lnk(lnk),
		.i_req(req), .i_cmd(cmd), .i_sel(sel), .i_wdata(wdata), .o_busy(busy),
		.o_rvalid(rvalid), .o_rdata(rdata), .o_flag(flag), .o_ready(ready));
	// Empty flag fixed on socket 0; sockets 0 and 2 produce.
	sfp_device sfp_device_inst (.lnk(lnk), .i_arst_n(i_arst_n),
		.i_flag_mode(sfp_pkg::FLAG_EMPTY), .i_flag_fixed(1'b1),
		.i_flag_thread(2'h0), .i_sel_five_bit(1'b1), .i_sock_producer(4'h5),
		.o_pkt_commit(commit), .o_pkt_zero_len(zlp), .o_pkt_sock(psock));
	sfp_link_sva sfp_link_sva_inst (.link_clk(lnk.link_clk), .i_arst_n(i_arst_n),
		.fifo_chip_select_n(lnk.fifo_chip_select_n),
		.fifo_output_enable_n(lnk.fifo_output_enable_n),
		.fifo_read_strobe_n(lnk.fifo_read_strobe_n),
		.fifo_write_strobe_n(lnk.fifo_write_strobe_n),
		.socket_switch_strobe_n(lnk.socket_switch_strobe_n),
		.dq_master_oe_n(lnk.dq_master_oe_n), .dq_from_device(lnk.dq_from_device),
		.dq_device_oe_n(lnk.dq_device_oe_n), .flag_status(lnk.flag_status),
		.flag_thread_ready(lnk.flag_thread_ready));
	always #12.5 i_clk = ~i_clk;
	// Pulses are caught off the launching edge to avoid a race.
	always @(negedge i_clk) begin
		if (rvalid === 1'b1) rq.push_back(rdata);
	end
	always @(negedge lnk.link_clk) begin
		if (zlp === 1'b1) n_zlp++;
		if (commit === 1'b1) n_commit++;
	end
	// A hung handshake is cut short well past the expected run.
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One user command; the wait is bounded and flags get time to settle.
	task automatic op(input logic [1:0] c, input logic [4:0] s,
		input logic [15:0] d);
		int n;
		n = 0;
		@(negedge i_clk);
		req <= 1'b1;
		cmd <= c;
		sel <= s;
		wdata <= d;
		while (busy !== 1'b1 && n < 16) begin
			@(negedge i_clk);
			n++;
		end
		req <= 1'b0;
		while (busy !== 1'b0 && n < 200) begin
			@(negedge i_clk);
			n++;
		end
		check({15'h0, busy}, 16'h0000);
		repeat (12) @(negedge i_clk);
	endtask : op
	// Words written come back in order; the empty flag follows the level.
	task automatic t_fill_drain();
		check({15'h0, flag}, 16'h0000);
		for (int i = 0; i < 3; i++) op(2'h0, 5'h00, 16'ha5c0 + 16'(i));
		// flag is checked for data before the reads start.
		check({15'h0, flag}, 16'h0001);
		for (int i = 0; i < 3; i++) op(2'h1, 5'h00, 16'h0000);
		check(16'(rq.size()), 16'h0003);
		for (int i = 0; i < 3 && rq.size() > 0; i++) begin
			check(rq.pop_front(), 16'ha5c0 + 16'(i));
		end
		check({15'h0, flag}, 16'h0000);
	endtask : t_fill_drain
	// Packet end alone closes an empty packet on the addressed socket.
	task automatic t_zlp();
		int c0;
		int k0;
		c0 = n_zlp;
		k0 = n_commit;
		op(2'h2, 5'h01, 16'h0000);
		check(16'(n_zlp - c0), 16'h0001);
		check(16'(n_commit - k0), 16'h0001);
		check({14'h0, psock}, 16'h0001);
	endtask : t_zlp
	// Switching to a producer with room raises thread ready.
	task automatic t_switch();
		op(2'h3, 5'h02, 16'h0000);
		check({15'h0, ready}, 16'h0001);
		op(2'h3, 5'h00, 16'h0000);
		check({15'h0, ready}, 16'h0001);
	endtask : t_switch
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test
	initial begin
		repeat (16) @(negedge i_clk);
		i_arst_n = 1'b1;
		repeat (16) @(negedge i_clk);
		t_fill_drain();
		t_zlp();
		t_switch();
		finish_test();
	end
endmodule : sync_slave_fifo_port_tb
`default_nettype wire
